// *** design/ebr_ctrl.sv ***
`timescale 1ns/1ps
module ebr_ctrl
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [ebr_pkg::ebr_cs_w-1:0] cs_sel_i,
  input wire logic [ebr_pkg::ebr_wait_w-1:0] memory_cycle_wait_count_i,
  input wire logic rw_delay_i,
  input wire logic mux_mode_i,
  input wire logic tristate_wait_enable_i,
  input wire logic ready_n_i,
  input wire logic hold_n_i,
  input wire logic want_bus_i,
  output logic busy_o,
  output logic done_o,
  output logic bus_clock_output_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [ebr_pkg::ebr_cs_w-1:0] chip_select_outputs_o,
  output logic [ebr_pkg::ebr_cs_w-1:0] chip_select_outputs_oe_n_o,
  output logic bus_oe_n_o,
  output logic bus_release_ack_n_o,
  output logic bus_regain_request_n_o
);
  import ebr_pkg::*;
  ebr_state_t state_q;
  logic phase_q;
  logic rdy_s1_q, rdy_s2_q, hold_s1_q, hold_s2_q;
  logic [ebr_wait_w-1:0] cnt_q;
  logic wr_q;
  logic [ebr_cs_w-1:0] sel_q;
  logic tick;
  // bus clock rises when phase goes high; all bus decisions on that edge
  assign tick = ~phase_q;
  assign busy_o = (state_q != ebr_idle_s);
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      phase_q <= 1'b0;
    else
      phase_q <= ~phase_q;
  end
  assign bus_clock_output_o = phase_q;
  // [R4] two flops; async ready low 2 phases+10ns is always caught
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      rdy_s1_q <= 1'b1;
      rdy_s2_q <= 1'b1;
      hold_s1_q <= 1'b1;
      hold_s2_q <= 1'b1;
    end
    else
    begin
      rdy_s1_q <= ready_n_i;
      rdy_s2_q <= rdy_s1_q;
      hold_s1_q <= hold_n_i;
      hold_s2_q <= hold_s1_q;
    end
  end
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ebr_idle_s;
      cnt_q <= '0;
      wr_q <= 1'b0;
      sel_q <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (tick)
      begin
        unique case (state_q)
          ebr_idle_s:
          begin
            // [R15] release request seen on bus clock edge
            if (!hold_s2_q)
              state_q <= ebr_held_s;
            else if (start_i)
            begin
              wr_q <= write_i;
              sel_q <= cs_sel_i;
              cnt_q <= memory_cycle_wait_count_i;
              // [R6] delayed strobe spends one setup clock
              state_q <= rw_delay_i ? ebr_setup_s : ebr_wait_s;
            end
          end
          ebr_setup_s:
            state_q <= ebr_wait_s;
          ebr_wait_s:
          begin
            // [R5] programmed wait states first
            if (cnt_q == '0)
              state_q <= ebr_ready_s;
            else
              cnt_q <= cnt_q - 1'b1;
          end
          ebr_ready_s:
          begin
            // [R1] ready high: stay, sample again
            // [R2] ready low: end cycle
            if (!rdy_s2_q)
            begin
              done_o <= 1'b1;
              // [R7] mux adds wait states after the cycle
              // [R8] gap length by mode
              if (mux_mode_i)
              begin
                cnt_q <= {{(ebr_wait_w-2){1'b0}},
                  (tristate_wait_enable_i ? ebr_mux_tri_gap : ebr_mux_gap)} - 1'b1;
                state_q <= ebr_gap_s;
              end
              else
                state_q <= ebr_idle_s;
            end
          end
          ebr_gap_s:
          begin
            if (cnt_q == '0)
              state_q <= ebr_idle_s;
            else
              cnt_q <= cnt_q - 1'b1;
          end
          ebr_held_s:
          begin
            // [R12] regain only when hold withdrawn
            // [R13] regardless of own request
            if (hold_s2_q)
              state_q <= ebr_regain_s;
          end
          ebr_regain_s:
            // [R14] bus driven again, next cycle may start
            state_q <= ebr_idle_s;
          default:
            state_q <= ebr_idle_s;
        endcase
      end
    end
  end
  // [R9] acknowledge only from idle or held state, reached after cycle end
  // [R15] ack and regain request change on tick, ack stays in held
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      bus_release_ack_n_o <= 1'b1;
      bus_regain_request_n_o <= 1'b1;
    end
    else if (tick)
    begin
      // [R16] active low outputs
      bus_release_ack_n_o <= !((state_q == ebr_idle_s && !hold_s2_q) ||
        (state_q == ebr_held_s && !hold_s2_q));
      // [R11] request only once ack already granted
      bus_regain_request_n_o <= !(state_q == ebr_held_s && !bus_release_ack_n_o && want_bus_i && !hold_s2_q);
    end
  end
  // [R10] chip selects and bus released while held
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      chip_select_outputs_o <= ebr_cs_idle;
      chip_select_outputs_oe_n_o <= '0;
      bus_oe_n_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
    end
    else
    begin
      chip_select_outputs_oe_n_o <= (state_q == ebr_held_s) ? ebr_cs_idle : '0;
      bus_oe_n_o <= (state_q == ebr_held_s);
      chip_select_outputs_o <= (state_q == ebr_wait_s || state_q == ebr_ready_s ||
        state_q == ebr_setup_s) ? ~sel_q : ebr_cs_idle;
      rd_n_o <= !(!wr_q && (state_q == ebr_wait_s || state_q == ebr_ready_s));
      wr_n_o <= !(wr_q && (state_q == ebr_wait_s || state_q == ebr_ready_s));
    end
  end
  // [R2] cycle ends only with ready sampled low
  a_ready_end: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R2]
    $rose(done_o) |-> $past(!rdy_s2_q, 1) && $past(state_q, 1) == ebr_ready_s)
    else $error("cycle ended without ready");
  a_ready_wait: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R1]
    (tick && state_q == ebr_ready_s && rdy_s2_q) |=> state_q == ebr_ready_s)
    else $error("ready high did not wait");
  a_ack_held: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R15]
    (state_q == ebr_held_s && !hold_s2_q && tick) |=> !bus_release_ack_n_o)
    else $error("ack dropped while held");
  a_no_ack_cycle: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R9]
    (state_q == ebr_ready_s || state_q == ebr_wait_s) |-> bus_release_ack_n_o)
    else $error("ack during cycle");
  a_cs_release: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R10]
    (state_q == ebr_held_s) |=> chip_select_outputs_oe_n_o == ebr_cs_idle && bus_oe_n_o)
    else $error("bus not released");
  a_bus_regain_request_after: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R11]
    $fell(bus_regain_request_n_o) |-> $past(!bus_release_ack_n_o, 1))
    else $error("regain before ack");
  a_regain_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R12]
    (state_q == ebr_held_s && tick && hold_s2_q) |=> state_q == ebr_regain_s)
    else $error("no regain");
  a_mux_gap: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R8]
    (state_q == ebr_ready_s && tick && !rdy_s2_q && mux_mode_i && tristate_wait_enable_i)
    |=> state_q == ebr_gap_s [*4] ##1 state_q == ebr_idle_s)
    else $error("mux gap wrong");
  a_single_gap: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R7]
    (state_q == ebr_ready_s && tick && !rdy_s2_q && mux_mode_i && !tristate_wait_enable_i)
    |=> state_q == ebr_gap_s [*2] ##1 state_q == ebr_idle_s)
    else $error("mux wait state wrong");
  a_demux_no_gap: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R8]
    (state_q == ebr_ready_s && tick && !rdy_s2_q && !mux_mode_i) |=> state_q == ebr_idle_s)
    else $error("demux gap not zero");
  a_held_strobes: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R10]
    (state_q == ebr_held_s) |-> rd_n_o && wr_n_o)
    else $error("strobe active while held");
  c_mux_gap: cover property (@(posedge clock_i) state_q == ebr_gap_s);
  c_read: cover property (@(posedge clock_i) $fell(rd_n_o));
  c_write: cover property (@(posedge clock_i) $fell(wr_n_o));
  c_hold: cover property (@(posedge clock_i) state_q == ebr_regain_s);
endmodule : ebr_ctrl

// *** design/ebr_pkg.sv ***
// How it works
// [R1] ready high at sample adds wait state
// [R2] ready low at sample ends cycle
// [R3] responder may drop ready after strobe
// [R4] async ready held low long enough
// [R5] programmed wait states before ready sampling
// [R6] strobe leading edge follows read/write delay
// [R7] multiplexed bus adds mux, optional tristate wait
// [R8] gap two bus clocks mux+tristate, else less
// [R9] finish running cycle before acknowledging release
// [R10] release chip selects and bus while held
// [R11] regain request only after acknowledge edge
// [R12] regain starts when release request goes away
// [R13] release withdrawn unasked still regains normally
// [R14] next cycle after bus driven again
// [R15] hold sampled and outputs change on bus clock
// [R16] handshake signals all active low
package ebr_pkg;
  localparam int unsigned ebr_clk_mhz = 40;
  localparam int unsigned ebr_wait_w = 4;
  localparam int unsigned ebr_cs_w = 5;
  localparam logic [ebr_cs_w-1:0] ebr_cs_idle = 5'h1f;
  localparam logic [1:0] ebr_mux_gap = 2'h1;
  localparam logic [1:0] ebr_mux_tri_gap = 2'h2;
  typedef enum logic [6:0]
  {
    ebr_idle_s   = 7'h01,
    ebr_setup_s  = 7'h02,
    ebr_wait_s   = 7'h04,
    ebr_ready_s  = 7'h08,
    ebr_gap_s    = 7'h10,
    ebr_held_s   = 7'h20,
    ebr_regain_s = 7'h40
  } ebr_state_t;
endpackage : ebr_pkg

// *** testbench/ebr_resp_model.sv ***
`timescale 1ns/1ps
module ebr_resp_model
(
  input wire logic clock_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [3:0] lat_i,
  output logic ready_n_o
);
  logic [3:0] cnt_q = 4'h0;
  initial ready_n_o = 1'b1;
  always @(negedge clock_i)
  begin
    if (rd_n_i && wr_n_i)
    begin
      cnt_q <= 4'h0;
      ready_n_o <= 1'b1;
    end
    else if (cnt_q == lat_i)
      ready_n_o <= 1'b0;
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule : ebr_resp_model

// *** testbench/ext_bus_ready_and_hold_arbitration_tb_top.sv ***
`timescale 1ns/1ps
module ext_bus_ready_and_hold_arbitration_tb_top;
  import ebr_pkg::*;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0, write_i = 1'b0, rw_delay_i = 1'b0;
  logic mux_mode_i = 1'b0, tristate_wait_enable_i = 1'b0, hold_n_i = 1'b1, want_bus_i = 1'b0;
  logic [ebr_cs_w-1:0] cs_sel_i = 5'h04;
  logic [ebr_wait_w-1:0] memory_cycle_wait_count_i = 4'h0;
  logic [3:0] lat = 4'h0;
  logic ready_n_i, busy_o, done_o, bus_clock_output_o, rd_n_o, wr_n_o, bus_oe_n_o;
  logic bus_release_ack_n_o, bus_regain_request_n_o;
  logic [ebr_cs_w-1:0] chip_select_outputs_o, chip_select_outputs_oe_n_o;
  int miscompares = 0, checks_done = 0, cycles = 0, lead = 0, lead0 = 0;
  initial forever #12.5 clock_i = ~clock_i;
  ebr_ctrl dut (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .start_i(start_i),
    .write_i(write_i),
    .cs_sel_i(cs_sel_i),
    .memory_cycle_wait_count_i(memory_cycle_wait_count_i),
    .rw_delay_i(rw_delay_i),
    .mux_mode_i(mux_mode_i),
    .tristate_wait_enable_i(tristate_wait_enable_i),
    .ready_n_i(ready_n_i),
    .hold_n_i(hold_n_i),
    .want_bus_i(want_bus_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .bus_clock_output_o(bus_clock_output_o),
    .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o),
    .chip_select_outputs_o(chip_select_outputs_o),
    .chip_select_outputs_oe_n_o(chip_select_outputs_oe_n_o),
    .bus_oe_n_o(bus_oe_n_o),
    .bus_release_ack_n_o(bus_release_ack_n_o),
    .bus_regain_request_n_o(bus_regain_request_n_o)
  );
  ebr_resp_model resp (.clock_i(clock_i), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .lat_i(lat), .ready_n_o(ready_n_i));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // hang guard, far above the longest test
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic await(ref logic s, input logic v);
    int t = 0;
    while (s !== v && t < 100)
    begin
      @(negedge clock_i);
      t++;
    end
    check({7'h0, s}, {7'h0, v});
  endtask : await
  task automatic bus_cycle(input logic wr, input int gap);
    int low = 0;
    int t = 0;
    int tail = 0;
    int bound = 0;
    @(negedge clock_i);
    // start is only taken in idle, not while regain or gap runs
    await(busy_o, 1'b0);
    write_i = wr;
    start_i = 1'b1;
    await(busy_o, 1'b1);
    start_i = 1'b0;
    while (done_o !== 1'b1 && t < 200)
    begin
      @(negedge clock_i);
      t++;
      if ((wr ? wr_n_o : rd_n_o) === 1'b0)
      begin
        if (low == 0)
          lead = t;
        low++;
        check({wr ? rd_n_o : wr_n_o, chip_select_outputs_o}, {1'b1, ~cs_sel_i});
        check({7'h0, bus_release_ack_n_o}, 8'h01);
      end
    end
    // strobe ends a few clocks after ready, or after the wait states
    bound = 2 * int'(memory_cycle_wait_count_i) + 6;
    if (int'(lat) + 6 > bound)
      bound = int'(lat) + 6;
    check(8'(low >= int'(lat) + 3), 8'h01);
    check(8'(low <= bound), 8'h01);
    check(8'(low >= 2 * (int'(memory_cycle_wait_count_i) + 1)), 8'h01);
    await(done_o, 1'b1);
    while (busy_o === 1'b1 && tail < 10)
    begin
      @(negedge clock_i);
      tail++;
    end
    // demux leaves no gap, mux one or two bus clocks
    check(8'(tail), 8'(2 * gap));
    $display("cycle done wr %0d gap %0d strobe %0d", wr, gap, low);
  endtask : bus_cycle
  initial
  begin
    repeat (12) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    check({4'h0, bus_release_ack_n_o, bus_regain_request_n_o, rd_n_o, wr_n_o}, 8'h0f);
    for (int i = 0; i < 4; i++)
    begin
      rw_delay_i = i[0];
      memory_cycle_wait_count_i = i[1] ? 4'h3 : 4'h0;
      // long latency once so ready, not the wait count, ends the cycle
      lat = (i == 2) ? 4'hc : 4'h1;
      bus_cycle(i[0], 0);
      if (i == 0)
        lead0 = lead;
      if (i == 1)
        check(8'(lead - lead0), 8'h02);
    end
    mux_mode_i = 1'b1;
    bus_cycle(1'b0, 1);
    tristate_wait_enable_i = 1'b1;
    bus_cycle(1'b1, 2);
    {mux_mode_i, tristate_wait_enable_i, want_bus_i} = 3'h1;
    memory_cycle_wait_count_i = 4'h2;
    fork
      bus_cycle(1'b0, 0);
      begin
        repeat (5) @(negedge clock_i);
        hold_n_i = 1'b0;
      end
    join
    await(bus_release_ack_n_o, 1'b0);
    // bus enables follow the state one clock after the acknowledge
    @(negedge clock_i);
    check({2'h0, bus_oe_n_o, chip_select_outputs_oe_n_o}, 8'h3f);
    await(bus_regain_request_n_o, 1'b0);
    start_i = 1'b1;
    repeat (6) @(negedge clock_i);
    start_i = 1'b0;
    check({5'h0, busy_o, rd_n_o, wr_n_o}, 8'h07);
    hold_n_i = 1'b1;
    await(bus_release_ack_n_o, 1'b1);
    @(negedge clock_i);
    check({2'h0, bus_oe_n_o, chip_select_outputs_oe_n_o}, 8'h00);
    bus_cycle(1'b1, 0);
    $display("release with regain request done");
    want_bus_i = 1'b0;
    hold_n_i = 1'b0;
    await(bus_release_ack_n_o, 1'b0);
    repeat (8) @(negedge clock_i);
    check({7'h0, bus_regain_request_n_o}, 8'h01);
    hold_n_i = 1'b1;
    await(bus_release_ack_n_o, 1'b1);
    bus_cycle(1'b0, 0);
    $display("unasked release withdrawal done");
    wrap_up();
  end
endmodule : ext_bus_ready_and_hold_arbitration_tb_top
